// ### pcbd_pkg.sv
// shared constants and types for the phase-locked clock bank divider
package pcbd_pkg;
	// settling interval after any lock disturbance
	localparam int LOCK_TIME_US = 50;
	localparam int CLK_MHZ = 40;
	localparam int LOCK_CYCLES = LOCK_TIME_US * CLK_MHZ;
	// synchroniser lane positions
	localparam int SY_W = 8;
	localparam int SY_REF = 0;
	localparam int SY_FB = 1;
	localparam int SY_SEL_LO = 2;
	localparam int SY_SEL_HI = 3;
	localparam int SY_OE_N = 4;
	localparam int SY_CLR_N = 5;
	localparam int SY_TEST = 6;
	localparam int SY_CFG = 7;
	// idle levels of the pins: enable and clear are inactive high
	localparam logic [7:0] SY_RST = 8'h30;
	localparam int BANKS = 4;
	localparam int PER_W = 8;
	localparam logic [PER_W-1:0] PER_MAX = 8'hff;
	localparam logic [1:0] PHASE_LAST = 2'h3;
	localparam logic [1:0] PHASE_ALIGN = 2'h2;
	localparam logic [1:0] PHASE_CLEAR = 2'h0;
	typedef enum logic [1:0] {
		LK_UNLOCKED = 2'b00,
		LK_SETTLING = 2'b01,
		LK_LOCKED = 2'b11
	} pcbd_lock_st_t;
endpackage : pcbd_pkg

// ### pcbd_lock_if.sv
// carrier between the bank divider and its lock timer
`timescale 1ns/10ps
interface pcbd_lock_if;
	logic disturb;
	logic locked;
	modport ctrl (output disturb, input locked);
	modport timer (input disturb, output locked);
endinterface : pcbd_lock_if

// ### pcbd_lock_timer.sv
// lock settling timer: holds lock low for a set interval after a disturbance
`timescale 1ns/10ps
module pcbd_lock_timer #(
	parameter int LOCK_CYCLES = pcbd_pkg::LOCK_CYCLES
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic ce,
	pcbd_lock_if.timer lk
);
	localparam int CW = $clog2(LOCK_CYCLES + 1);
	localparam logic [CW-1:0] LAST = CW'(LOCK_CYCLES - 1);

	typedef struct packed {
		pcbd_pkg::pcbd_lock_st_t st;
		logic [CW-1:0] cnt;
	} pcbd_tmr_t;

	pcbd_tmr_t st_r;
	pcbd_tmr_t st_nxt;

	always_comb begin
		st_nxt = st_r;
		case (st_r.st)
			pcbd_pkg::LK_UNLOCKED: begin
				st_nxt.st = pcbd_pkg::LK_SETTLING;
				st_nxt.cnt = '0;
			end
			pcbd_pkg::LK_SETTLING: begin
				st_nxt.cnt = st_r.cnt + CW'(1);
				if (st_r.cnt == LAST) begin
					st_nxt.st = pcbd_pkg::LK_LOCKED;
				end
			end
			default: begin
				st_nxt.st = pcbd_pkg::LK_LOCKED;
			end
		endcase
		// any disturbance restarts the whole interval
		if (lk.disturb) begin
			st_nxt.st = pcbd_pkg::LK_UNLOCKED;
			st_nxt.cnt = '0;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			st_r <= '{st: pcbd_pkg::LK_UNLOCKED, cnt: '0};
		end else if (ce) begin
			st_r <= st_nxt;
		end
	end

	assign lk.locked = (st_r.st == pcbd_pkg::LK_LOCKED);

	chk_settle_bound: assert property (@(posedge clk) disable iff (srst)
		(st_r.st == pcbd_pkg::LK_SETTLING) |-> (st_r.cnt <= LAST))
		else $error("settling count ran past its limit");
	chk_lock_entry: assert property (@(posedge clk) disable iff (srst)
		$rose(lk.locked) |-> ($past(st_r.cnt) == LAST))
		else $error("lock asserted before the settling interval ended");
endmodule : pcbd_lock_timer

// ### pcbd_clock_bank.sv
// twelve-output clock bank divider with select decode, bypass and lock tracking
`timescale 1ns/10ps
module pcbd_clock_bank #(
	parameter int LOCK_CYCLES = pcbd_pkg::LOCK_CYCLES
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic ce,
	input wire logic reference_clock_in,
	input wire logic loop_feedback_in,
	input wire logic bank_rate_select_hi,
	input wire logic bank_rate_select_lo,
	input wire logic config_double_rate,
	input wire logic output_enable_n,
	input wire logic ratio_clear_n,
	input wire logic test_bypass,
	output logic [2:0] bank_one_outputs,
	output logic [2:0] bank_two_outputs,
	output logic [2:0] bank_three_outputs,
	output logic [2:0] bank_four_outputs,
	output logic [11:0] outputs_drive_n,
	output logic lock_ok
);
	typedef struct packed {
		logic [pcbd_pkg::SY_W-1:0] sy1;
		logic [pcbd_pkg::SY_W-1:0] sy2;
		logic [pcbd_pkg::SY_W-1:0] sy3;
		logic [pcbd_pkg::SY_W-1:0] lvl;
		logic [1:0] cnt;
		logic [pcbd_pkg::BANKS-1:0] fast;
		logic [pcbd_pkg::PER_W-1:0] per;
		logic [pcbd_pkg::PER_W-1:0] per_last;
		logic ref_seen;
		logic [pcbd_pkg::BANKS-1:0] bank;
		logic [11:0] drive_n;
	} pcbd_top_t;

	localparam pcbd_top_t TOP_RST = '{
		sy1: pcbd_pkg::SY_RST,
		sy2: pcbd_pkg::SY_RST,
		sy3: pcbd_pkg::SY_RST,
		lvl: pcbd_pkg::SY_RST,
		cnt: pcbd_pkg::PHASE_CLEAR,
		fast: '0,
		per: '0,
		per_last: '0,
		ref_seen: 1'b0,
		bank: '0,
		drive_n: 12'hfff
	};

	pcbd_top_t st_r;
	pcbd_top_t st_nxt;
	logic [pcbd_pkg::SY_W-1:0] pins;
	logic [pcbd_pkg::BANKS-1:0] fast_dec;
	logic [1:0] sel;
	logic ref_rise;
	logic clr_fall;
	logic oe_fall;
	logic sel_move;
	logic per_jump;

	pcbd_lock_if lk ();

	pcbd_lock_timer #(
		.LOCK_CYCLES(LOCK_CYCLES)
	) u_lock (
		.clk(clk),
		.srst(srst),
		.ce(ce),
		.lk(lk)
	);

	assign pins = {config_double_rate, test_bypass, ratio_clear_n, output_enable_n,
		bank_rate_select_hi, bank_rate_select_lo, loop_feedback_in, reference_clock_in};
	assign sel = st_r.lvl[pcbd_pkg::SY_SEL_HI:pcbd_pkg::SY_SEL_LO];

	// half-rate config slows banks below the select value; double-rate speeds
	// the banks at or above it, and none at select zero
	for (genvar b = 0; b < pcbd_pkg::BANKS; b++) begin : g_dec
		assign fast_dec[b] = (2'(b) >= sel) &&
			(!st_r.lvl[pcbd_pkg::SY_CFG] || sel != 2'h0);
	end

	always_comb begin
		st_nxt = st_r;
		st_nxt.sy1 = pins;
		st_nxt.sy2 = st_r.sy1;
		st_nxt.sy3 = st_r.sy2;
		// a lane moves only once the second and third stages agree
		st_nxt.lvl = (st_r.sy2 & st_r.sy3) | (st_r.lvl & (st_r.sy2 | st_r.sy3));
		ref_rise = st_nxt.lvl[pcbd_pkg::SY_REF] && !st_r.lvl[pcbd_pkg::SY_REF];
		clr_fall = !st_nxt.lvl[pcbd_pkg::SY_CLR_N] && st_r.lvl[pcbd_pkg::SY_CLR_N];
		oe_fall = !st_nxt.lvl[pcbd_pkg::SY_OE_N] && st_r.lvl[pcbd_pkg::SY_OE_N];
		sel_move = (st_nxt.lvl[pcbd_pkg::SY_SEL_HI:pcbd_pkg::SY_SEL_LO] != sel) ||
			(st_nxt.lvl[pcbd_pkg::SY_CFG] != st_r.lvl[pcbd_pkg::SY_CFG]);
		per_jump = 1'b0;

		// reference period tracking flags a frequency change
		if (ref_rise) begin
			st_nxt.per = '0;
			st_nxt.ref_seen = 1'b1;
			// the count up to the first edge after reset is no whole period
			st_nxt.per_last = st_r.ref_seen ? st_r.per : '0;
			per_jump = (st_r.per_last != '0) &&
				(({1'b0, st_r.per} > {1'b0, st_r.per_last} + 9'h1) ||
				({1'b0, st_r.per_last} > {1'b0, st_r.per} + 9'h1));
		end else if (st_r.per != pcbd_pkg::PER_MAX) begin
			st_nxt.per = st_r.per + 8'h1;
		end

		// one free divider feeds every bank
		st_nxt.cnt = st_r.cnt + 2'h1;
		if (ref_rise && !lk.locked) begin
			st_nxt.cnt = pcbd_pkg::PHASE_ALIGN;
		end
		if (clr_fall) begin
			st_nxt.cnt = pcbd_pkg::PHASE_CLEAR;
		end
		// new ratios only at the wrap so no bank sees a runt pulse
		if (st_r.cnt == pcbd_pkg::PHASE_LAST) begin
			st_nxt.fast = fast_dec;
		end

		for (int b = 0; b < pcbd_pkg::BANKS; b++) begin
			if (st_nxt.lvl[pcbd_pkg::SY_TEST]) begin
				st_nxt.bank[b] = st_nxt.lvl[pcbd_pkg::SY_REF];
			end else if (st_nxt.fast[b]) begin
				st_nxt.bank[b] = !st_nxt.cnt[0];
			end else begin
				st_nxt.bank[b] = st_nxt.cnt[1];
			end
		end
		st_nxt.drive_n = {12{st_nxt.lvl[pcbd_pkg::SY_OE_N]}};

		lk.disturb = sel_move || oe_fall || per_jump;
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			st_r <= TOP_RST;
		end else if (ce) begin
			st_r <= st_nxt;
		end
	end

	// each bank drives its three pins from one flop, so they never skew in logic
	assign bank_one_outputs = {3{st_r.bank[0]}};
	assign bank_two_outputs = {3{st_r.bank[1]}};
	assign bank_three_outputs = {3{st_r.bank[2]}};
	assign bank_four_outputs = {3{st_r.bank[3]}};
	assign outputs_drive_n = st_r.drive_n;
	assign lock_ok = lk.locked;

	chk_bank_groups: assert property (@(posedge clk) disable iff (srst)
		(bank_four_outputs == {3{st_r.bank[3]}}) &&
		(outputs_drive_n == {12{outputs_drive_n[0]}}))
		else $error("bank pins or enables split apart");
	chk_decode_half: assert property (@(posedge clk) disable iff (srst)
		(ce && st_r.cnt == 2'h3 && !st_r.lvl[pcbd_pkg::SY_CFG] && sel == 2'h2)
		|=> (st_r.fast == 4'hc))
		else $error("half-rate decode wrong for select 10");
	chk_decode_double: assert property (@(posedge clk) disable iff (srst)
		(ce && st_r.cnt == 2'h3 && st_r.lvl[pcbd_pkg::SY_CFG] && sel == 2'h1)
		|=> (st_r.fast == 4'he))
		else $error("double-rate decode wrong for select 01");
	chk_slow_rise: assert property (@(posedge clk) disable iff (srst)
		(ce && !st_nxt.lvl[pcbd_pkg::SY_TEST] && !st_r.fast[0] && st_r.cnt == 2'h1
		&& !ref_rise && !clr_fall) |=> st_r.bank[0])
		else $error("slow bank missed its rising phase");
	chk_fast_rise: assert property (@(posedge clk) disable iff (srst)
		(ce && !st_nxt.lvl[pcbd_pkg::SY_TEST] && st_r.fast[3] && st_r.cnt == 2'h1)
		|=> st_r.bank[3])
		else $error("fast bank missed its rising phase");
	chk_rate_phase: assert property (@(posedge clk) disable iff (srst)
		(st_r.cnt != 2'h3) |=> (st_r.fast == $past(st_r.fast)))
		else $error("bank rate changed away from the wrap");
	chk_realign: assert property (@(posedge clk) disable iff (srst)
		(ce && ref_rise && !lock_ok && !clr_fall) |=> (st_r.cnt == 2'h2))
		else $error("divider not aligned to reference edge");
	chk_float_off: assert property (@(posedge clk) disable iff (srst)
		(ce && st_nxt.lvl[pcbd_pkg::SY_OE_N]) |=> (outputs_drive_n == 12'hfff))
		else $error("outputs driven while disabled");
	chk_test_bypass: assert property (@(posedge clk) disable iff (srst)
		(ce && st_nxt.lvl[pcbd_pkg::SY_TEST])
		|=> (st_r.bank == {4{$past(st_nxt.lvl[pcbd_pkg::SY_REF])}}))
		else $error("bypass does not follow reference");
	chk_clear_div: assert property (@(posedge clk) disable iff (srst)
		(ce && clr_fall) |=> (st_r.cnt == 2'h0))
		else $error("ratio clear did not reset divider");
	chk_unlock_hold: assert property (@(posedge clk) disable iff (srst)
		(ce && lk.disturb) |=> !lock_ok [*2])
		else $error("lock stayed high after a disturbance");
endmodule : pcbd_clock_bank

// ### pcbd_ref_src.sv
// reference clock source and board feedback wire for the clock bank
`timescale 1ns/10ps
module pcbd_ref_src #(
	parameter int HALF = 4
) (
	input wire logic clk,
	input wire logic fb_tap,
	output logic reference_clock_in,
	output logic loop_feedback_in
);
	int cnt = 0;
	logic ref_r = 1'b0;
	// rate is scaled to the model clock; fixed period and phase, never jumps
	// equal halves give a 50 percent duty cycle
	always @(negedge clk) begin
		if (cnt == HALF - 1) begin
			cnt <= 0;
			ref_r <= ~ref_r;
		end else begin
			cnt <= cnt + 1;
		end
	end
	assign reference_clock_in = ref_r;
	// one base-rate output wired back, chosen by the bench
	assign loop_feedback_in = fb_tap;
endmodule : pcbd_ref_src

// ### pcbd_clock_bank_tb_top.sv
// self-checking bench for the clock bank divider
`timescale 1ns/10ps
module pcbd_clock_bank_tb_top;
	localparam int LK = 8;
	logic clk, srst, ce, ref_clk, fb, sel_hi, sel_lo, cfg_dbl, oe_n, clr_n, test_byp, lock_ok;
	logic [2:0] b1, b2, b3, b4;
	logic [11:0] drv_n;
	logic [11:0] tg;
	int num_errors = 0;
	int checks = 0;
	int n;
	logic [1:0] sel;
	pcbd_clock_bank #(.LOCK_CYCLES(LK)) DUT (.clk(clk), .srst(srst), .ce(ce),
		.reference_clock_in(ref_clk), .loop_feedback_in(fb), .bank_rate_select_hi(sel_hi),
		.bank_rate_select_lo(sel_lo), .config_double_rate(cfg_dbl), .output_enable_n(oe_n),
		.ratio_clear_n(clr_n), .test_bypass(test_byp), .bank_one_outputs(b1),
		.bank_two_outputs(b2), .bank_three_outputs(b3), .bank_four_outputs(b4),
		.outputs_drive_n(drv_n), .lock_ok(lock_ok));
	// bank one is base rate in double mode, bank four in half mode
	pcbd_ref_src #(.HALF(4)) u_src (.clk(clk), .fb_tap(cfg_dbl ? b1[0] : b4[0]),
		.reference_clock_in(ref_clk), .loop_feedback_in(fb));
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	function automatic logic [2:0] bank(input int b);
		case (b)
			0: return b1;
			1: return b2;
			2: return b3;
			default: return b4;
		endcase
	endfunction : bank
	task automatic cmp(input logic [11:0] got, input logic [11:0] exp);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp
	// bounded so a stuck timer cannot hang the run
	task automatic wait_lock(output int k);
		k = 0;
		while (lock_ok !== 1'b1 && k < 100) begin
			@(negedge clk);
			k++;
		end
	endtask : wait_lock
	// after a disturbance lock must drop, then return after the settling interval
	task automatic relock;
		int k;
		repeat (6) @(negedge clk);
		cmp({11'h0, lock_ok}, 12'h0);
		wait_lock(k);
		cmp(12'(k >= LK - 4 && k <= LK + 6), 12'h1);
	endtask : relock
	task automatic count_toggles(input int b, output logic [11:0] t);
		logic [2:0] prev;
		logic [2:0] cur;
		t = '0;
		prev = bank(b);
		repeat (16) begin
			@(negedge clk);
			cur = bank(b);
			cmp(12'(cur === 3'h0 || cur === 3'h7), 12'h1);
			if (cur !== prev) t++;
			prev = cur;
		end
	endtask : count_toggles
	task automatic give_verdict;
		$display("errors=%0d checks=%0d", num_errors, checks);
		if (num_errors == 0 && checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : give_verdict
	initial begin
		#100000;
		num_errors++;
		give_verdict();
	end
	initial begin
		srst = 1'b1;
		ce = 1'b1;
		sel_hi = 1'b0;
		sel_lo = 1'b0;
		cfg_dbl = 1'b0;
		oe_n = 1'b1;
		clr_n = 1'b1;
		test_byp = 1'b0;
		repeat (4) @(negedge clk);
		srst = 1'b0;
		cmp({11'h0, lock_ok}, 12'h0);
		cmp(drv_n, 12'hfff);
		wait_lock(n);
		cmp({11'h0, lock_ok}, 12'h1);
		oe_n = 1'b0;
		relock();
		cmp(drv_n, 12'h000);
		// each step changes the select or mode, so every step disturbs lock
		for (int c = 0; c < 2; c++) begin
			for (int i = 0; i < 4; i++) begin
				sel = 2'(i + 1);
				cfg_dbl = c[0];
				sel_hi = sel[1];
				sel_lo = sel[0];
				relock();
				for (int b = 0; b < 4; b++) begin
					count_toggles(b, tg);
					if (c == 1 ? (sel != 0 && b >= sel) : !(b < sel)) begin
						cmp(tg, 12'h010);
					end else begin
						cmp(tg, 12'h008);
					end
				end
			end
		end
		// clear one clock after a reference pin rise, where the free phase would be 3
		@(posedge ref_clk);
		@(negedge clk);
		clr_n = 1'b0;
		repeat (4) @(negedge clk);
		for (int p = 0; p < 4; p++) begin
			cmp({9'h0, b1}, {9'h0, {3{p[1]}}});
			@(negedge clk);
		end
		clr_n = 1'b1;
		test_byp = 1'b1;
		repeat (6) @(negedge clk);
		count_toggles(0, tg);
		cmp(tg, 12'h004);
		count_toggles(3, tg);
		cmp(tg, 12'h004);
		oe_n = 1'b1;
		repeat (6) @(negedge clk);
		cmp(drv_n, 12'hfff);
		// four cycles is half a reference period, so a running bank would differ
		ce = 1'b0;
		tg = {b1, b2, b3, b4};
		repeat (4) @(negedge clk);
		cmp({b1, b2, b3, b4}, tg);
		ce = 1'b1;
		give_verdict();
	end
endmodule : pcbd_clock_bank_tb_top
